// ---- include/sarcc_pkg.sv ----
`default_nettype none
package sarcc_pkg;
    // register offsets on the 8-bit register port
    localparam logic [7:0] ADDR_CFG      = 8'hbc;
    localparam logic [7:0] ADDR_CTRL     = 8'he8;
    localparam logic [7:0] ADDR_RES_LOW  = 8'hbe;
    localparam logic [7:0] ADDR_RES_HIGH = 8'hbf;
    localparam logic [7:0] ADDR_WIN_LOW  = 8'hc4;
    localparam logic [7:0] ADDR_WIN_HIGH = 8'hc5;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hc6;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hc7;

    // reset values
    localparam logic [7:0] CFG_RESET     = 8'hf8;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] WIN_LOW_RESET = 8'h00;
    localparam logic [7:0] WIN_HIGH_RST  = 8'hff;

    // configuration fields
    localparam int DIV_MSB  = 7;
    localparam int DIV_LSB  = 3;
    localparam int GAIN_MSB = 2;

    // control register bit positions
    localparam int CTL_EN    = 7;
    localparam int CTL_TM    = 6;
    localparam int CTL_DONE  = 5;
    localparam int CTL_BUSY  = 4;
    localparam int CTL_CM_HI = 3;
    localparam int CTL_CM_LO = 2;
    localparam int CTL_WIN   = 1;
    localparam int CTL_LJST  = 0;

    // interrupt status and mask bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_WIN  = 1;

    // start source codes
    localparam logic [1:0] CM_SOFT   = 2'b00;
    localparam logic [1:0] CM_TIMER3 = 2'b01;
    localparam logic [1:0] CM_STROBE = 2'b10;
    localparam logic [1:0] CM_TIMER2 = 2'b11;

    // trigger input indices
    localparam int TRG_T3 = 0;
    localparam int TRG_EXT = 1;
    localparam int TRG_T2 = 2;

    // amplifier gain codes driven to the analog core
    localparam logic [2:0] GAIN_1    = 3'h0;
    localparam logic [2:0] GAIN_2    = 3'h1;
    localparam logic [2:0] GAIN_4    = 3'h2;
    localparam logic [2:0] GAIN_8    = 3'h3;
    localparam logic [2:0] GAIN_16   = 3'h4;
    localparam logic [2:0] GAIN_HALF = 3'h5;

    // timed tracking length in conversion clocks
    localparam logic [1:0] TRACK_CLKS = 2'd3;
    localparam int         RES_W      = 10;

    typedef enum logic [1:0] {
        SARCC_IDLE  = 2'b00,
        SARCC_TRACK = 2'b01,
        SARCC_CONV  = 2'b10
    } sarcc_state_t;
endpackage
`default_nettype wire

// ---- design/sarcc_top.sv ----
`default_nettype none
module sarcc_top
    import sarcc_pkg::*;
(
    // clock and reset
    input  wire  logic                  sys_clk,
    input  wire  logic                  arst_n,
    // register port
    input  wire  logic [7:0]            reg_addr,
    input  wire  logic [7:0]            reg_wdata,
    input  wire  logic                  reg_wr,
    input  wire  logic                  reg_rd,
    output var   logic [7:0]            reg_rdata,
    // trigger inputs, asynchronous
    input  wire  logic                  timer3_overflow,
    input  wire  logic                  timer2_overflow,
    input  wire  logic                  external_convert_strobe,
    // analog core
    output logic                        conversion_clock,
    output var   logic                  sar_power_en,
    output var   logic                  sar_track,
    output var   logic                  sar_start,
    output var   logic [2:0]            amp_gain_select,
    input  wire  logic                  sar_result_valid,
    input  wire  logic [sarcc_pkg::RES_W-1:0] sar_result,
    // interrupt
    output logic                        irq
);
    import sarcc_pkg::*;

    logic [7:0]        cfg_ff, ctrl_ff, win_lo_ff, win_hi_ff;
    logic [7:0]        irq_stat_ff, irq_mask_ff, nxt_irq_stat;
    logic [7:0]        nxt_ctrl, rd_mux;
    logic [RES_W-1:0]  res_ff;
    logic [4:0]        div_cnt_ff, nxt_div_cnt;
    logic              div_clk_ff;
    logic [2:0]        sync1_ff, sync2_ff, prev_ff;
    logic [1:0]        trk_cnt_ff, nxt_trk_cnt;
    sarcc_state_t      state_ff, nxt_state;

    // register decode
    wire wr_cfg   = reg_wr && (reg_addr == ADDR_CFG);
    wire wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_wlo   = reg_wr && (reg_addr == ADDR_WIN_LOW);
    wire wr_whi   = reg_wr && (reg_addr == ADDR_WIN_HIGH);
    wire wr_istat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
    wire wr_imask = reg_wr && (reg_addr == ADDR_IRQ_MASK);

    // control fields
    wire [4:0] div_n   = cfg_ff[DIV_MSB:DIV_LSB];
    wire       en      = ctrl_ff[CTL_EN];
    wire       tm      = ctrl_ff[CTL_TM];
    wire [1:0] cm      = ctrl_ff[CTL_CM_HI:CTL_CM_LO];
    wire       ljst    = ctrl_ff[CTL_LJST];
    wire       busy    = (state_ff != SARCC_IDLE);

    // a control write counts for a start in its own cycle, so enable, mode and
    // source may be set by the very write that sets the busy bit
    wire [7:0] ctrl_eff = wr_ctrl ? reg_wdata : ctrl_ff;
    wire       en_eff   = ctrl_eff[CTL_EN];
    wire       tm_eff   = ctrl_eff[CTL_TM];
    wire [1:0] cm_eff   = ctrl_eff[CTL_CM_HI:CTL_CM_LO];

    // conversion clock tick: one system cycle per conversion clock rising edge
    // divided period
    wire div_wrap = (div_cnt_ff == div_n);
    wire sar_tick = (div_n == 5'h00) || (div_wrap && !div_clk_ff);
    // a clock mux is used for the bypass; glitches only when software retunes
    assign conversion_clock = (div_n == 5'h00) ? sys_clk : div_clk_ff;
    assign nxt_div_cnt      = (div_wrap || div_n == 5'h00) ? 5'h00 : div_cnt_ff + 5'h01;

    // divider registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_ff <= 5'h00;
            div_clk_ff <= 1'b0;
        end else begin
            div_cnt_ff <= nxt_div_cnt;
            div_clk_ff <= (div_n != 5'h00 && div_wrap) ? !div_clk_ff : div_clk_ff;
        end
    end

    // two-stage sync then edge detect; first stage read only by second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff  <= 3'h0;
        end else begin
            sync1_ff <= {timer2_overflow, external_convert_strobe, timer3_overflow};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    wire [2:0] rise    = sync2_ff & ~prev_ff;
    wire       strobe_low = !sync2_ff[TRG_EXT];

    // software start only when the source is soft
    wire soft_go = wr_ctrl && reg_wdata[CTL_BUSY] && (cm_eff == CM_SOFT);
    wire hw_go   = (cm == CM_TIMER3 && rise[TRG_T3]) ||
                   (cm == CM_STROBE && rise[TRG_EXT]) ||
                   (cm == CM_TIMER2 && rise[TRG_T2]);
    wire go      = en_eff && (soft_go || hw_go);
    // strobe mode with timed tracking converts at once on the rising edge
    wire go_now  = !tm_eff || (cm_eff == CM_STROBE);

    // sequencer
    always_comb begin
        nxt_state   = state_ff;
        nxt_trk_cnt = trk_cnt_ff;
        unique case (state_ff)
            SARCC_IDLE: begin
                if (go) begin
                    nxt_state   = go_now ? SARCC_CONV : SARCC_TRACK;
                    nxt_trk_cnt = 2'd0;
                end
            end
            SARCC_TRACK: begin
                if (sar_tick) begin
                    nxt_trk_cnt = trk_cnt_ff + 2'd1;
                    if (trk_cnt_ff == TRACK_CLKS - 2'd1) begin
                        nxt_state = SARCC_CONV;
                    end
                end
            end
            SARCC_CONV: begin
                if (sar_result_valid) begin
                    nxt_state = SARCC_IDLE;
                end
            end
            default: nxt_state = SARCC_IDLE;
        endcase
        if (!en_eff) begin
            nxt_state = SARCC_IDLE;
        end
    end

    // end of conversion is the busy falling edge
    wire conv_end = (state_ff == SARCC_CONV) && sar_result_valid && en;
    // window comparison on the upper eight result bits
    wire win_hit  = conv_end && (sar_result[RES_W-1:2] >= win_lo_ff) &&
                    (sar_result[RES_W-1:2] <= win_hi_ff);

    // control register: hardware set wins over a software clear
    always_comb begin
        nxt_ctrl = wr_ctrl ? reg_wdata : ctrl_ff;
        nxt_ctrl[CTL_BUSY] = (nxt_state != SARCC_IDLE);
        if (conv_end) begin
            nxt_ctrl[CTL_DONE] = 1'b1;
        end
        if (win_hit) begin
            nxt_ctrl[CTL_WIN] = 1'b1;
        end
    end

    // interrupt status: write one clears, new events win
    always_comb begin
        nxt_irq_stat = wr_istat ? (irq_stat_ff & ~reg_wdata) : irq_stat_ff;
        nxt_irq_stat[IRQ_DONE] = nxt_irq_stat[IRQ_DONE] | conv_end;
        nxt_irq_stat[IRQ_WIN]  = nxt_irq_stat[IRQ_WIN] | win_hit;
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // register file and sequencer state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff      <= CFG_RESET;
            ctrl_ff     <= CTRL_RESET;
            win_lo_ff   <= WIN_LOW_RESET;
            win_hi_ff   <= WIN_HIGH_RST;
            irq_stat_ff <= 8'h00;
            irq_mask_ff <= 8'h00;
            res_ff      <= '0;
            state_ff    <= SARCC_IDLE;
            trk_cnt_ff  <= 2'd0;
        end else begin
            cfg_ff      <= wr_cfg ? reg_wdata : cfg_ff;
            ctrl_ff     <= nxt_ctrl;
            win_lo_ff   <= wr_wlo ? reg_wdata : win_lo_ff;
            win_hi_ff   <= wr_whi ? reg_wdata : win_hi_ff;
            irq_stat_ff <= nxt_irq_stat & 8'h03;
            irq_mask_ff <= wr_imask ? (reg_wdata & 8'h03) : irq_mask_ff;
            res_ff      <= conv_end ? sar_result : res_ff;
            state_ff    <= nxt_state;
            trk_cnt_ff  <= nxt_trk_cnt;
        end
    end

    // justification applied when the result is read
    wire [7:0] res_hi = ljst ? res_ff[RES_W-1:2] : {6'h00, res_ff[RES_W-1:8]};
    wire [7:0] res_lo = ljst ? {res_ff[1:0], 6'h00} : res_ff[7:0];

    // read mux; unmapped addresses read zero
    assign rd_mux = (reg_addr == ADDR_CFG)      ? cfg_ff :
                    (reg_addr == ADDR_CTRL)     ? ctrl_ff :
                    (reg_addr == ADDR_RES_HIGH) ? res_hi :
                    (reg_addr == ADDR_RES_LOW)  ? res_lo :
                    (reg_addr == ADDR_WIN_LOW)  ? win_lo_ff :
                    (reg_addr == ADDR_WIN_HIGH) ? win_hi_ff :
                    (reg_addr == ADDR_IRQ_STAT) ? irq_stat_ff :
                    (reg_addr == ADDR_IRQ_MASK) ? irq_mask_ff : 8'h00;

    wire [2:0] g = cfg_ff[GAIN_MSB:0];
    wire [2:0] gain_dec = g[2] ? (g[1] ? GAIN_HALF : GAIN_16) : g;

    wire trk_now = en_eff && ((!tm && nxt_state != SARCC_CONV) ||
                          (tm && cm == CM_STROBE && nxt_state == SARCC_IDLE && strobe_low) ||
                          (nxt_state == SARCC_TRACK));

    // analog outputs except conversion_clock, and read data, all registered
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata       <= 8'h00;
            sar_power_en    <= 1'b0;
            sar_track       <= 1'b0;
            sar_start       <= 1'b0;
            amp_gain_select <= GAIN_1;
        end else begin
            reg_rdata       <= reg_rd ? rd_mux : 8'h00;
            // power follows enable; the written value, so a start in the same write finds the core powered
            sar_power_en    <= en_eff;
            sar_track       <= trk_now;
            sar_start       <= (nxt_state == SARCC_CONV) && (state_ff != SARCC_CONV);
            amp_gain_select <= gain_dec;
        end
    end

    // helper: cycles since last conversion clock tick
    logic [6:0] gap_ff;
    logic       seen_ff;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_ff  <= 7'h00;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= sar_tick ? 7'h00 : gap_ff + 7'h01;
            // a divider change restarts the period check, the first gap after it is mixed
            seen_ff <= wr_cfg ? 1'b0 : (seen_ff | sar_tick);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_div_period;
        sar_tick && seen_ff && div_n != 5'h00 && $stable(cfg_ff) && $past(div_n) == div_n
            |-> gap_ff == {1'b0, div_n, 1'b1};
    endproperty
    a_div_period: assert property (p_div_period) else $error("divider period wrong");

    property p_nodiv;
        div_n == 5'h00 && $past(div_n) == 5'h00 |-> sar_tick && div_cnt_ff == 5'h00;
    endproperty
    a_nodiv: assert property (p_nodiv) else $error("undivided tick missing");

    property p_gain;
        !wr_cfg && g[2:1] == 2'b11 |=> amp_gain_select == GAIN_HALF;
    endproperty
    a_gain: assert property (p_gain) else $error("gain decode wrong");

    property p_shutdown;
        !en_eff |=> !sar_power_en && state_ff == SARCC_IDLE;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not held");

    property p_track0;
        en && !tm && !wr_ctrl && state_ff == SARCC_IDLE && !go |=> sar_track;
    endproperty
    a_track0: assert property (p_track0) else $error("continuous tracking lost");

    property p_done;
        conv_end |=> ctrl_ff[CTL_DONE] && !busy;
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");

    property p_nosoft;
        state_ff == SARCC_IDLE && wr_ctrl && cm_eff != CM_SOFT && !hw_go |=> state_ff == SARCC_IDLE;
    endproperty
    a_nosoft: assert property (p_nosoft) else $error("soft start in hw mode");

    property p_track3;
        state_ff == SARCC_TRACK && nxt_state == SARCC_CONV && en |-> trk_cnt_ff == 2'd2 && sar_tick;
    endproperty
    a_track3: assert property (p_track3) else $error("tracking length wrong");

    property p_win;
        win_hit |=> ctrl_ff[CTL_WIN] ##1 (ctrl_ff[CTL_WIN] || $past(wr_ctrl));
    endproperty
    a_win: assert property (p_win) else $error("window flag lost");

    property p_ljst;
        reg_rd && reg_addr == ADDR_RES_HIGH && ljst |=> reg_rdata == $past(res_ff[RES_W-1:2]);
    endproperty
    a_ljst: assert property (p_ljst) else $error("left justify wrong");

    c_soft: cover property (soft_go && en_eff ##[1:300] conv_end);
    c_timed: cover property (state_ff == SARCC_TRACK ##[1:200] state_ff == SARCC_CONV);
    c_strobe: cover property (cm == CM_STROBE && rise[TRG_EXT] && en ##1 state_ff == SARCC_CONV);
endmodule
`default_nettype wire

// ---- verification/sarcc_core_model.sv ----
`default_nettype none
module sarcc_core_model #(
    parameter int DLY = 12
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // control from the block
    input  wire logic                        sar_start,
    input  wire logic                        sar_power_en,
    // value the bench wants converted
    input  wire logic [sarcc_pkg::RES_W-1:0] res_in,
    // result back to the block
    output var  logic                        sar_result_valid,
    output var  logic [sarcc_pkg::RES_W-1:0] sar_result
);
    import sarcc_pkg::*;

    int cnt_ff;

    // a conversion takes DLY cycles; losing power abandons it silently
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff           <= 0;
            sar_result_valid <= 1'b0;
        end else begin
            sar_result_valid <= 1'b0;
            if (sar_start === 1'b1 && sar_power_en === 1'b1) begin
                cnt_ff <= DLY;
            end else if (cnt_ff > 0) begin
                cnt_ff <= cnt_ff - 1;
                sar_result_valid <= (cnt_ff == 1);
            end
            if (sar_power_en !== 1'b1) begin
                cnt_ff <= 0;
            end
        end
    end

    // outside the valid cycle the bus shows inverted data, so stale words cannot match
    always_comb sar_result = sar_result_valid ? res_in : ~res_in;
endmodule
`default_nettype wire

// ---- verification/sarcc_top_tb_top.sv ----
`default_nettype none
module sarcc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sarcc_pkg::*;

    localparam int P     = 8;      // conversion clock period at divider 3, the 2.5 MHz ceiling
    localparam int LIMIT = 20000;  // far above the thousand or so cycles needed

    // clock, reset, register port
    logic             sys_clk;
    logic             arst_n;
    logic [7:0]       reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [7:0]       reg_rdata;
    // triggers and analog side
    logic [2:0]       trg;
    logic             conversion_clock;
    logic             sar_power_en;
    logic             sar_track;
    logic             sar_start;
    logic [2:0]       amp_gain_select;
    logic             sar_result_valid;
    logic [RES_W-1:0] sar_result;
    logic [RES_W-1:0] res_in;
    logic             irq;
    // bookkeeping
    int               miscompares;
    int               n_compared;
    int               n_start;
    int               trk_cnt;
    int               trk_last;
    int               cyc;
    int               b;
    logic [2:0]       gexp [8];
    int               tix [3];
    logic [1:0]       cms [3];

    sarcc_top u_sarcc_top (
        .sys_clk                 (sys_clk),
        .arst_n                  (arst_n),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rdata               (reg_rdata),
        .timer3_overflow         (trg[TRG_T3]),
        .timer2_overflow         (trg[TRG_T2]),
        .external_convert_strobe (trg[TRG_EXT]),
        .conversion_clock        (conversion_clock),
        .sar_power_en            (sar_power_en),
        .sar_track               (sar_track),
        .sar_start               (sar_start),
        .amp_gain_select         (amp_gain_select),
        .sar_result_valid        (sar_result_valid),
        .sar_result              (sar_result),
        .irq                     (irq)
    );

    sarcc_core_model u_sarcc_core_model (
        .sys_clk          (sys_clk),
        .arst_n           (arst_n),
        .sar_start        (sar_start),
        .sar_power_en     (sar_power_en),
        .res_in           (res_in),
        .sar_result_valid (sar_result_valid),
        .sar_result       (sar_result)
    );

    task automatic wrap_up();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask

    // a gap cycle after each write keeps the strobe from being driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, e, m);
        @(posedge sys_clk);
    endtask

    task automatic fire(input int i, input int len);
        trg[i] <= ~trg[i];
        repeat (len) @(posedge sys_clk);
        trg[i] <= ~trg[i];
        @(posedge sys_clk);
    endtask

    task automatic wait_start();
        int k;
        k = 0;
        // the start pulse is counted at the edge, so a pulse that ends as a task returns is not missed
        while (n_start == b && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        chk(k < 300, 1'b1, "start seen");
    endtask

    task automatic quiet(input int k);
        repeat (80) @(posedge sys_clk);
        chk(16'(n_start - b), 16'(k), "start count");
    endtask

    task automatic per(output int p);
        int   k;
        logic prev;
        p = 0;
        k = -1;
        prev = 1'b1;
        repeat (100) begin
            @(negedge sys_clk);
            if (k >= 0) k++;
            if (prev === 1'b0 && conversion_clock === 1'b1) begin
                if (k > 0 && p == 0) p = k;
                k = 0;
            end
            prev = conversion_clock;
        end
        @(posedge sys_clk);
    endtask

    task automatic conv(input logic [7:0] c, input int t);
        b = n_start;
        wr(ADDR_CTRL, c);
        if (t >= 0) fire(t, 4);
        wait_start();
        @(negedge sys_clk);
        chk(sar_track, 1'b0, "track during conversion");
        @(posedge sys_clk);
        rdc(ADDR_CTRL, c | 8'h10, "busy while converting");
        repeat (20) @(posedge sys_clk);
    endtask

    // clock at 20 MHz
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // start counting, tracking run lengths and the hang guard
    always @(posedge sys_clk) begin
        if (sar_start === 1'b1) n_start <= n_start + 1;
        if (sar_track !== 1'b1 && trk_cnt > 0) trk_last <= trk_cnt;
        trk_cnt <= (sar_track === 1'b1) ? trk_cnt + 1 : 0;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        res_in = 10'h2b5;
        trg = 3'b000;
        trg[TRG_EXT] = 1'b1;
        {miscompares, n_compared, n_start, trk_cnt, trk_last, cyc} = '0;
        gexp = '{GAIN_1, GAIN_2, GAIN_4, GAIN_8, GAIN_16, GAIN_16, GAIN_HALF, GAIN_HALF};
        tix = '{TRG_T3, TRG_EXT, TRG_T2};
        cms = '{CM_TIMER3, CM_STROBE, CM_TIMER2};
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rdc(ADDR_CFG, CFG_RESET, "cfg reset");
        rdc(ADDR_CTRL, CTRL_RESET, "ctrl reset");
        rdc(8'h00, 8'h00, "unmapped read");
        chk(sar_power_en, 1'b0, "power at reset");
        wr(ADDR_CFG, 8'h08);
        per(b);
        chk(16'(b), 16'(2 * (1 + 1)), "divider 1 period");
        wr(ADDR_CFG, 8'h50);
        per(b);
        chk(16'(b), 16'(2 * (10 + 1)), "divider 10 period");
        wr(ADDR_CFG, 8'h00);
        repeat (3) begin
            @(posedge sys_clk);
            #10 chk(conversion_clock, 1'b1, "undivided high");
            #20 chk(conversion_clock, 1'b0, "undivided low");
        end
        @(posedge sys_clk);
        for (int g = 0; g < 8; g++) begin
            wr(ADDR_CFG, {5'd3, 3'(g)});
            @(negedge sys_clk);
            chk(amp_gain_select, gexp[g], "gain code");
            @(posedge sys_clk);
        end
        $display("test config done");
        conv(8'h90, -1);
        rdc(ADDR_CTRL, 8'ha2, "done and window set");
        chk(irq, 1'b0, "masked irq");
        wr(ADDR_IRQ_MASK, 8'h03);
        chk(irq, 1'b1, "irq raised");
        wr(ADDR_IRQ_STAT, 8'h01);
        chk(irq, 1'b1, "window still pending");
        wr(ADDR_IRQ_STAT, 8'h02);
        chk(irq, 1'b0, "irq cleared");
        rdc(ADDR_RES_HIGH, 8'h02, "right high");
        rdc(ADDR_RES_LOW, 8'hb5, "right low");
        wr(ADDR_CTRL, 8'h81);
        rdc(ADDR_CTRL, 8'h81, "flags cleared by write");
        rdc(ADDR_RES_HIGH, 8'had, "left high");
        rdc(ADDR_RES_LOW, 8'h40, "left low");
        wr(ADDR_WIN_LOW, 8'hf0);
        conv(8'h91, -1);
        rdc(ADDR_CTRL, 8'ha1, "done without window");
        res_in <= 10'h3ff;
        conv(8'h91, -1);
        rdc(ADDR_CTRL, 8'ha3, "window hit, done kept");
        $display("test soft start done");
        b = n_start;
        wr(ADDR_CTRL, 8'h94);
        quiet(0);
        for (int i = 0; i < 3; i++) begin
            conv({4'h8, cms[i], 2'b00}, tix[i]);
        end
        chk(sar_track, 1'b1, "idle tracking");
        b = n_start;
        fire(TRG_T2, 40);
        quiet(1);
        $display("test triggers done");
        b = n_start;
        wr(ADDR_CTRL, 8'h50);
        quiet(0);
        chk({sar_power_en, sar_track}, 2'b00, "shutdown");
        conv(8'hd0, -1);
        chk(trk_last inside {[2 * P + 1:3 * P]}, 1'b1, "timed track soft");
        conv(8'hc4, TRG_T3);
        chk(trk_last inside {[2 * P + 1:3 * P]}, 1'b1, "timed track timer");
        wr(ADDR_CTRL, 8'hc8);
        trg[TRG_EXT] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk(sar_track, 1'b1, "track while strobe low");
        b = n_start;
        trg[TRG_EXT] <= 1'b1;
        wait_start();
        repeat (20) @(posedge sys_clk);
        $display("test track modes done");
        wrap_up();
    end
endmodule
`default_nettype wire
